// ===== verilog/prht_regs.vh
// encodings shared by the partial register hazard tracker
// assumes the decoder drives these codes on the instruction stream
`ifndef PRHT_REGS_VH
`define PRHT_REGS_VH

// general register write and read widths
`define PRHT_W_LO_BYTE 3'h0
`define PRHT_W_HI_BYTE 3'h1
`define PRHT_W_WORD 3'h2
`define PRHT_W_DWORD 3'h3
`define PRHT_W_QWORD 3'h4

// width ranks used for the read against last piece hazard compare
`define PRHT_RANK_BYTE 3'h1
`define PRHT_RANK_WORD 3'h2
`define PRHT_RANK_DWORD 3'h3
`define PRHT_RANK_QWORD 3'h4
`define PRHT_RANK_RST 3'h4

// vector write kinds
`define PRHT_V_FULL_COPY 3'h0
`define PRHT_V_QUADWORD_MOVE 3'h1
`define PRHT_V_LOW_HALF_LOAD 3'h2
`define PRHT_V_HIGH_HALF_DOUBLE_LOAD 3'h3
`define PRHT_V_SCALAR_SINGLE_MOVE 3'h4
`define PRHT_V_SCALAR_DOUBLE_MOVE 3'h5

// flag write kinds
`define PRHT_F_NONE 3'h0
`define PRHT_F_FULL 3'h1
`define PRHT_F_PARTIAL 3'h2
`define PRHT_F_SHIFT_VAR 3'h3
`define PRHT_F_SHIFT_IMM 3'h4
`define PRHT_F_EIGHT_BYTE_COMPARE_EXCHANGE 3'h5
`define PRHT_F_ROTATE 3'h6
`define PRHT_F_SET_CARRY_OR_DIRECTION 3'h7

`define PRHT_SHIFT_ONE 6'h01

`endif

// ===== verilog/prht_tracker.v
// rename stage partial register and partial flag hazard tracker
// assumes the front end holds an instruction until ins_accept_out,
// and completion and retire pulses come from logic on core_clk_in
`timescale 1ns/10ps
`default_nettype none
`include "prht_regs.vh"

// Overview of operation
// RULE_01 - general register writes are tracked as byte, word, dword, and quadword only in 64-bit mode.
// RULE_02 - a read wider than the last separate piece written to a register with pieces in flight is held back.
// RULE_03 - a dword write clears the upper half and counts as a full write without hazard.
// RULE_04 - a zero-extending byte or word load counts as a full write with no old-value dependency.
// RULE_05 - half loads and scalar register moves into a vector register mark a dependency on its old value.
// RULE_06 - full vector copies and zeroing 64-bit loads write the whole register with no old-value dependency.
// RULE_07 - every shift except by immediate count one may leave flags untouched, so those shifts are taken as partial flag writers.
// RULE_08 - a flag consumer after a partial flag writer is stalled until that writer retires.
// RULE_09 - eight-byte compare-exchange, rotates, set carry and set direction are partial flag writers.
// RULE_10 - a shift by immediate count one never causes the partial flag stall.
// RULE_11 - a writer of all flags ends any partial flag stall for later consumers.
// RULE_12 - a held read is released once all earlier writers are done and the merged value is forwarded.
module prht_tracker #(
	parameter NREG = 16,
	parameter IDXW = 4,
	parameter CNTW = 4
) (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire mode64_in,
	input wire ins_valid_in,
	input wire gpr_wr_en_in,
	input wire [IDXW-1:0] gpr_wr_idx_in,
	input wire [2:0] gpr_wr_width_in,
	input wire gpr_wr_zext_in,
	input wire gpr_rd_en_in,
	input wire [IDXW-1:0] gpr_rd_idx_in,
	input wire [2:0] gpr_rd_width_in,
	input wire gpr_done_in,
	input wire [IDXW-1:0] gpr_done_idx_in,
	input wire vec_wr_en_in,
	input wire [2:0] vec_wr_kind_in,
	input wire [2:0] flag_wr_kind_in,
	input wire [5:0] shift_count_in,
	input wire flag_rd_in,
	input wire flag_retire_in,
	output reg ins_accept_out,
	output reg gpr_stall_out,
	output reg flag_stall_out,
	output reg gpr_merge_out,
	output reg vec_dep_out
);

	// per register pending writers and last piece rank
	reg [CNTW-1:0] pend_r [0:NREG-1];
	reg [NREG-1:0] frag_r;
	reg [2:0] last_rank_r [0:NREG-1];
	reg [CNTW-1:0] pflag_cnt_r;
	reg pflag_live_r;
	reg held_r;

	// combinational decode of the instruction
	reg gpr_hit;
	reg flag_hit;
	reg go;
	reg wr_full;
	reg fw_partial;
	reg fw_full;
	reg [2:0] rd_rank;
	reg [CNTW-1:0] pflag_cnt_nxt;
	integer i;

	function [2:0] prht_rank;
		input [2:0] w;
		input m64;
		begin
			case (w)
			`PRHT_W_LO_BYTE: prht_rank = `PRHT_RANK_BYTE;
			`PRHT_W_HI_BYTE: prht_rank = `PRHT_RANK_BYTE;
			`PRHT_W_WORD: prht_rank = `PRHT_RANK_WORD;
			`PRHT_W_DWORD: prht_rank = `PRHT_RANK_DWORD;
			`PRHT_W_QWORD: begin
				// quadword only exists in 64-bit mode, see RULE_01
				if (m64) begin
					prht_rank = `PRHT_RANK_QWORD;
				end else begin
					prht_rank = `PRHT_RANK_DWORD;
				end
			end
			default: prht_rank = `PRHT_RANK_DWORD;
			endcase
		end
	endfunction

	// next count after one more writer
	function [CNTW-1:0] prht_inc;
		input [CNTW-1:0] c;
		begin
			prht_inc = c + {{(CNTW-1){1'b0}}, 1'b1};
		end
	endfunction

	// next count after one writer finishes
	function [CNTW-1:0] prht_dec;
		input [CNTW-1:0] c;
		begin
			prht_dec = c - {{(CNTW-1){1'b0}}, 1'b1};
		end
	endfunction

	// full writes break the old value, see RULE_03 and RULE_04
	function prht_full_write;
		input [2:0] w;
		input z;
		input m64;
		begin
			if (z) begin
				prht_full_write = 1'b1;
			end else if (prht_rank(w, m64) >= `PRHT_RANK_DWORD) begin
				prht_full_write = 1'b1;
			end else begin
				prht_full_write = 1'b0;
			end
		end
	endfunction

	// flag writer class, bit 1 full, bit 0 partial
	function [1:0] prht_flag_class;
		input [2:0] k;
		input [5:0] cnt;
		begin
			case (k)
			`PRHT_F_NONE: begin
				prht_flag_class = 2'h0;
			end
			`PRHT_F_FULL: begin
				prht_flag_class = 2'h2; // see RULE_11
			end
			`PRHT_F_PARTIAL: begin
				prht_flag_class = 2'h1;
			end
			`PRHT_F_SHIFT_VAR: begin
				// count known only at execution, see RULE_07
				prht_flag_class = 2'h1;
			end
			`PRHT_F_SHIFT_IMM: begin
				// count one has its own path, see RULE_10
				if (cnt == `PRHT_SHIFT_ONE) begin
					prht_flag_class = 2'h2;
				end else begin
					prht_flag_class = 2'h1; // see RULE_07
				end
			end
			`PRHT_F_EIGHT_BYTE_COMPARE_EXCHANGE: begin
				prht_flag_class = 2'h1; // see RULE_09
			end
			`PRHT_F_ROTATE: begin
				prht_flag_class = 2'h1; // see RULE_09
			end
			`PRHT_F_SET_CARRY_OR_DIRECTION: begin
				prht_flag_class = 2'h1; // see RULE_09
			end
			default: begin
				prht_flag_class = 2'h0;
			end
			endcase
		end
	endfunction

	// vector kinds that keep old lanes, see RULE_05 and RULE_06
	function prht_vec_partial;
		input [2:0] k;
		begin
			case (k)
			`PRHT_V_FULL_COPY: begin
				prht_vec_partial = 1'b0; // see RULE_06
			end
			`PRHT_V_QUADWORD_MOVE: begin
				prht_vec_partial = 1'b0; // see RULE_06
			end
			`PRHT_V_LOW_HALF_LOAD: begin
				prht_vec_partial = 1'b1; // see RULE_05
			end
			`PRHT_V_HIGH_HALF_DOUBLE_LOAD: begin
				prht_vec_partial = 1'b1; // see RULE_05
			end
			`PRHT_V_SCALAR_SINGLE_MOVE: begin
				prht_vec_partial = 1'b1; // see RULE_05
			end
			`PRHT_V_SCALAR_DOUBLE_MOVE: begin
				prht_vec_partial = 1'b1; // see RULE_05
			end
			default: begin
				prht_vec_partial = 1'b0;
			end
			endcase
		end
	endfunction

	// hazard detection on the instruction being renamed
	always @* begin
		rd_rank = prht_rank(gpr_rd_width_in, mode64_in);
		// wider read over separately written pieces, see RULE_02
		gpr_hit = gpr_rd_en_in && frag_r[gpr_rd_idx_in] &&
			(pend_r[gpr_rd_idx_in] != {CNTW{1'b0}}) &&
			(rd_rank > last_rank_r[gpr_rd_idx_in]);
		// stall lasts until the partial writers retire, see RULE_08
		flag_hit = flag_rd_in && pflag_live_r &&
			(pflag_cnt_r != {CNTW{1'b0}});
		go = ins_valid_in && !ins_accept_out && !gpr_hit && !flag_hit;

		// dword and zero-extended loads are full, see RULE_03 and RULE_04
		wr_full =
			prht_full_write(gpr_wr_width_in, gpr_wr_zext_in, mode64_in);

		// flag writer kind decode, see RULE_07 and RULE_10
		{fw_full, fw_partial} =
			prht_flag_class(flag_wr_kind_in, shift_count_in);

		pflag_cnt_nxt = pflag_cnt_r;
		if (go && fw_partial && !flag_retire_in) begin
			pflag_cnt_nxt = prht_inc(pflag_cnt_r);
		end else if (!(go && fw_partial) && flag_retire_in &&
			pflag_cnt_r != {CNTW{1'b0}}) begin
			pflag_cnt_nxt = prht_dec(pflag_cnt_r);
		end
	end

	// general register piece tracking
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			frag_r <= {NREG{1'b0}};
			for (i = 0; i < NREG; i = i + 1) begin
				pend_r[i] <= {CNTW{1'b0}};
				last_rank_r[i] <= `PRHT_RANK_RST;
			end
		end else begin
			for (i = 0; i < NREG; i = i + 1) begin
				// release when earlier writers finish, see RULE_12
				if (go && gpr_wr_en_in && gpr_wr_idx_in == i &&
					!(gpr_done_in && gpr_done_idx_in == i)) begin
					pend_r[i] <= prht_inc(pend_r[i]);
				end else if (gpr_done_in && gpr_done_idx_in == i &&
					!(go && gpr_wr_en_in && gpr_wr_idx_in == i) &&
					pend_r[i] != {CNTW{1'b0}}) begin
					pend_r[i] <= prht_dec(pend_r[i]);
				end
			end

			if (go && gpr_wr_en_in) begin
				// track each write at its granularity, see RULE_01
				if (wr_full) begin
					frag_r[gpr_wr_idx_in] <= 1'b0; // see RULE_03
					last_rank_r[gpr_wr_idx_in] <= `PRHT_RANK_QWORD;
				end else begin
					frag_r[gpr_wr_idx_in] <= 1'b1;
					last_rank_r[gpr_wr_idx_in] <=
						prht_rank(gpr_wr_width_in, mode64_in);
				end
			end
		end
	end

	// flag writer tracking
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pflag_cnt_r <= {CNTW{1'b0}};
			pflag_live_r <= 1'b0;
		end else begin
			// last flag writer kind decides the stall, see RULE_11
			pflag_cnt_r <= pflag_cnt_nxt;
			if (go && fw_partial) begin
				pflag_live_r <= 1'b1; // see RULE_08
			end else if (go && fw_full) begin
				pflag_live_r <= 1'b0; // see RULE_11
			end
		end
	end

	// registered answers to the front end
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ins_accept_out <= 1'b0;
			gpr_stall_out <= 1'b0;
			flag_stall_out <= 1'b0;
			gpr_merge_out <= 1'b0;
			vec_dep_out <= 1'b0;
			held_r <= 1'b0;
		end else begin
			ins_accept_out <= go;
			gpr_stall_out <= ins_valid_in && !ins_accept_out && gpr_hit;
			flag_stall_out <= ins_valid_in && !ins_accept_out && flag_hit;
			// merged value forwarded to a released reader, see RULE_12
			gpr_merge_out <= go && held_r;
			if (go) begin
				held_r <= 1'b0;
			end else if (ins_valid_in && !ins_accept_out && gpr_hit) begin
				held_r <= 1'b1;
			end

			// partial vector writes keep old lanes, see RULE_05 and RULE_06
			vec_dep_out <= go && vec_wr_en_in &&
				prht_vec_partial(vec_wr_kind_in);
		end
	end

endmodule
`default_nettype wire

// ===== test/prht_tracker_sva.sv
// assertions on the hazard tracker ports
// assumes one core clock and an async active low reset
`timescale 1ns/10ps
`default_nettype none
module prht_tracker_sva (
	input wire logic core_clk_in, reset_n_in, ins_valid_in, flag_rd_in,
	input wire logic gpr_rd_en_in, ins_accept_out, gpr_stall_out,
	input wire logic flag_stall_out, gpr_merge_out, vec_dep_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_held;
		gpr_stall_out ##1 !gpr_stall_out;
	endsequence
	a_held_free: assert property (s_held |-> gpr_merge_out)
		else $error("held read not merged");
	a_free_take: assert property (ins_valid_in && !ins_accept_out
		&& !gpr_rd_en_in && !flag_rd_in |=> ins_accept_out) else $error("no take");
	a_gpr_hold: assert property (gpr_stall_out |->
		!ins_accept_out && $past(gpr_rd_en_in)) else $error("gpr hold");
	a_flag_hold: assert property (flag_stall_out |->
		!ins_accept_out && $past(flag_rd_in)) else $error("flag hold");
	a_merge_take: assert property (gpr_merge_out |->
		ins_accept_out && $past(gpr_stall_out)) else $error("merge");
	a_vec_take: assert property (vec_dep_out |-> ins_accept_out)
		else $error("vec dep");
	a_take_once: assert property (ins_accept_out |=> !ins_accept_out)
		else $error("double take");
	a_flag_free: assert property (flag_stall_out ##1 !flag_stall_out
		|-> ins_accept_out) else $error("flag release");
endmodule
bind prht_tracker prht_tracker_sva i_prht_tracker_sva (.*);
`default_nettype wire

// ===== test/prht_tracker_test.sv
// self-checking bench for the hazard tracker
// assumes a 10 MHz core clock, inputs moved 1 ns after each edge
`timescale 1ns/10ps
`default_nettype none
module prht_tracker_test;
	logic core_clk_in = 0, reset_n_in = 0, mode64_in = 1, ins_valid_in = 0;
	logic gpr_wr_en_in = 0, gpr_wr_zext_in = 0, gpr_rd_en_in = 0, gpr_done_in = 0;
	logic vec_wr_en_in = 0, flag_rd_in = 0, flag_retire_in = 0;
	logic [3:0] gpr_wr_idx_in = 0, gpr_rd_idx_in = 0, gpr_done_idx_in = 0, res;
	logic [2:0] gpr_wr_width_in = 0, gpr_rd_width_in = 0, vec_wr_kind_in = 0;
	logic [2:0] flag_wr_kind_in = 0;
	logic [5:0] shift_count_in = 0;
	logic ins_accept_out, gpr_stall_out, flag_stall_out, gpr_merge_out;
	logic vec_dep_out;
	int n_fail = 0, check_count = 0, cyc = 0;
	prht_tracker i_prht_tracker (.*);
	initial forever #50 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (++cyc >= 2000) print_verdict;
	task chk(input logic [3:0] s, e);
		check_count++;
		if (s !== e) n_fail++;
		if (s !== e) $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
	endtask
	task print_verdict;
		if (cyc >= 2000) n_fail++;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// res = accept, stalled, merge, vector dependency
	task go;
		{res, ins_valid_in} = 5'h01;
		repeat (3) if (ins_valid_in) begin
			@(posedge core_clk_in);
			#1 res[2] |= gpr_stall_out | flag_stall_out;
			res[1:0] = {gpr_merge_out, vec_dep_out};
			res[3] = ins_accept_out;
			ins_valid_in = !ins_accept_out;
		end
	endtask
	task pls(input logic f);
		{flag_retire_in, gpr_done_in} = {f, !f};
		@(posedge core_clk_in);
		#1 {flag_retire_in, gpr_done_in} = 2'b00;
	endtask
	task gp(input logic rd, logic [3:0] r, logic [2:0] w, logic z);
		{gpr_rd_en_in, gpr_wr_en_in, gpr_wr_zext_in} = {rd, !rd, z};
		{gpr_rd_idx_in, gpr_wr_idx_in, gpr_done_idx_in} = {r, r, r};
		{gpr_rd_width_in, gpr_wr_width_in} = {w, w};
		go;
	endtask
	task t_gpr;
		gp(0, 4'h1, 3'h0, 0);
		gp(0, 4'h1, 3'h1, 0);
		gp(1, 4'h1, 3'h2, 0);
		chk(res, 4'h4);
		repeat (2) pls(0);
		go;
		chk(res, 4'ha);
		gp(0, 4'h2, 3'h2, 0);
		gp(0, 4'h2, 3'h3, 0);
		gp(1, 4'h2, 3'h4, 0);
		chk(res, 4'h8);
		gp(0, 4'h3, 3'h2, 0);
		gp(0, 4'h3, 3'h0, 1);
		gp(1, 4'h3, 3'h3, 0);
		chk(res, 4'h8);
	endtask
	task t_kinds;
		flag_rd_in = 1;
		for (int i = 0; i < 8; i++) begin
			{vec_wr_en_in, vec_wr_kind_in} = {i < 6, i[2:0]};
			flag_wr_kind_in = i ? i[2:0] : 3'h4;
			shift_count_in = {5'h00, i == 4};
			go;
			chk(res, {3'b100, i > 1 && i < 6});
			{vec_wr_en_in, flag_wr_kind_in} = 4'h0;
			go;
			chk(res, 4'h4 << (i == 1 || i == 4));
			pls(1);
			go;
			chk(res, 4'h8);
		end
	endtask
	initial begin
		repeat (4) @(posedge core_clk_in);
		#1 reset_n_in = 1;
		t_gpr;
		t_kinds;
		print_verdict;
	end
endmodule
`default_nettype wire
